// file: vlrl_top.v
// VLAN to filter group lookup, forwarding choice and per port rate limits.
// Assumes the switch fabric and port MACs share clk; registers over APB.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`include "vlrl_map.vh"

module vlrl_top #(
  parameter [31:0] INTERVAL_CYCLES = `VLRL_INTERVAL_MS * `VLRL_CLK_KHZ,
  parameter        LIM_W           = 12,
  parameter        CNT_W           = 24
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        lk_req,
  input  wire [2:0]  lk_port,
  input  wire        lk_tagged,
  input  wire [11:0] lk_vid,
  output reg         lk_group_valid_reg,
  output reg  [3:0]  lk_filter_group_id_reg,
  input  wire        res_valid,
  input  wire        res_static_hit,
  input  wire        res_use_group_match_flag,
  input  wire [3:0]  res_static_group,
  input  wire [4:0]  res_static_ports,
  input  wire        res_dyn_hit,
  input  wire [2:0]  res_dyn_port,
  input  wire        res_sa_hit,
  output reg         fwd_valid_reg,
  output reg  [4:0]  fwd_ports_reg,
  output reg         fwd_drop_reg,
  output reg         fwd_learn_reg,
  output reg         fwd_refresh_reg,
  output reg         busy_reg,
  input  wire [4:0]  rx_sof,
  input  wire [4:0]  rx_byte,
  input  wire [4:0]  rx_eof,
  input  wire [4:0]  rx_prio,
  input  wire [4:0]  tx_sof,
  input  wire [4:0]  tx_byte,
  input  wire [4:0]  tx_eof,
  input  wire [4:0]  tx_prio,
  output wire [9:0]  rx_stop,
  output wire [9:0]  tx_stop,
  output wire [4:0]  rx_fc
);

  localparam NP       = 5;
  localparam ST_IDLE  = 2'b01;
  localparam ST_WAIT  = 2'b10;

  reg  [31:0] ctrl_reg;
  reg  [31:0] vlan_mem [0:15];
  reg  [31:0] pc_mem   [0:NP-1];
  reg  [31:0] rxl_mem  [0:NP-1];
  reg  [31:0] txl_mem  [0:NP-1];
  reg  [31:0] sec_cnt_reg;
  reg         tick_reg;
  reg  [1:0]  state_reg;
  reg  [4:0]  mbr_reg;
  reg  [31:0] rd_data;
  reg         rd_ok;
  reg  [11:0] vid_eff;
  reg  [11:0] port_default_vlan;
  reg  [31:0] pc_cur;
  reg         vhit;
  reg  [3:0]  vfid;
  reg  [4:0]  vmbr;
  reg         drop;
  reg  [4:0]  ports;
  reg         static_ok;
  integer     i;
  integer     j;
  wire        vmode;
  wire        port_ok;
  wire        apb_done;
  wire [31:0] status;

  // Register group decode
  function hit_vlan;
    input [11:0] a;
    begin
      hit_vlan = (a & `VLRL_MASK_VLAN) == `VLRL_ADDR_VLAN_BASE;
    end
  endfunction

  function hit_grp;
    input [11:0] a;
    input [11:0] base;
    begin
      hit_grp = ((a & `VLRL_MASK_GROUP) == base) && (a[4:2] < 3'd5);
    end
  endfunction

  assign vmode    = ctrl_reg[`VLRL_CTRL_VLAN_BIT];
  assign port_ok  = lk_port < 3'd5;
  assign apb_done = psel & penable & pready;
  assign status   = {7'h00, rx_fc, tx_stop, rx_stop};

  always @(posedge clk) begin
    if (!nrst) begin
      sec_cnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'b0;
    end else if (sec_cnt_reg == INTERVAL_CYCLES - 1) begin
      sec_cnt_reg <= 32'h0000_0000;
      tick_reg    <= 1'b1;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
      tick_reg    <= 1'b0;
    end
  end

  // Read mux
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (paddr == `VLRL_ADDR_CTRL) begin
      rd_data = ctrl_reg;
    end else if (paddr == `VLRL_ADDR_STATUS) begin
      rd_data = status;
    end else if (hit_vlan(paddr)) begin
      rd_data = vlan_mem[paddr[5:2]];
    end else if (hit_grp(paddr, `VLRL_ADDR_PORT_BASE)) begin
      rd_data = pc_mem[paddr[4:2]];
    end else if (hit_grp(paddr, `VLRL_ADDR_RXLIM_BASE)) begin
      rd_data = rxl_mem[paddr[4:2]];
    end else if (hit_grp(paddr, `VLRL_ADDR_TXLIM_BASE)) begin
      rd_data = txl_mem[paddr[4:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // APB slave, one wait state
  always @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !rd_ok;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes
  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg <= `VLRL_CTRL_RST;
      for (i = 0; i < 16; i = i + 1) begin
        vlan_mem[i] <= `VLRL_VE_RST;
      end
      for (i = 0; i < NP; i = i + 1) begin
        pc_mem[i]  <= `VLRL_PC_RST;
        rxl_mem[i] <= `VLRL_LIM_RST;
        txl_mem[i] <= `VLRL_LIM_RST;
      end
    end else if (apb_done && pwrite) begin
      if (paddr == `VLRL_ADDR_CTRL) begin
        ctrl_reg <= pwdata & 32'h0000_0001;
      end else if (hit_vlan(paddr)) begin
        vlan_mem[paddr[5:2]] <= pwdata & 32'h003f_ffff;
      end else if (hit_grp(paddr, `VLRL_ADDR_PORT_BASE)) begin
        pc_mem[paddr[4:2]] <= pwdata & 32'h0fff_0063;
      end else if (hit_grp(paddr, `VLRL_ADDR_RXLIM_BASE)) begin
        rxl_mem[paddr[4:2]] <= pwdata & 32'h0fff_0fff;
      end else if (hit_grp(paddr, `VLRL_ADDR_TXLIM_BASE)) begin
        txl_mem[paddr[4:2]] <= pwdata & 32'h0fff_0fff;
      end
    end
  end

  // VLAN resolution and admission
  always @* begin
    pc_cur = port_ok ? pc_mem[lk_port] : `VLRL_PC_RST;
    port_default_vlan   = pc_cur[`VLRL_PC_PORT_DEFAULT_VLAN_LSB +: 12];
    vid_eff = (!lk_tagged || lk_vid == 12'h000) ? port_default_vlan : lk_vid;
    vhit    = 1'b0;
    vfid    = 4'h0;
    vmbr    = 5'h00;
    for (j = 0; j < 16; j = j + 1) begin
      if (!vhit && vlan_mem[j][`VLRL_VE_VALID_BIT] &&
          vlan_mem[j][`VLRL_VE_VID_LSB +: 12] == vid_eff) begin
        vhit = 1'b1;
        vfid = vlan_mem[j][`VLRL_VE_FID_LSB +: 4];
        vmbr = vlan_mem[j][`VLRL_VE_MBR_LSB +: 5];
      end
    end
    if (!vmode) begin
      vhit = 1'b1;
      vfid = 4'h0;
      vmbr = 5'h1f;
    end
    drop = !port_ok || !vhit;
    if (vmode && pc_cur[`VLRL_PC_FILTER_BIT] && !vmbr[lk_port]) begin
      drop = 1'b1;
    end
    if (vmode && pc_cur[`VLRL_PC_NONPVID_BIT] && vid_eff != port_default_vlan) begin
      drop = 1'b1;
    end
  end

  // Egress port choice
  always @* begin
    static_ok = res_static_hit &&
                (!res_use_group_match_flag || res_static_group == lk_filter_group_id_reg);
    if (static_ok) begin
      ports = res_static_ports;
    end else if (res_dyn_hit) begin
      ports = 5'h01 << res_dyn_port;
    end else begin
      ports = mbr_reg;
    end
  end

  // Lookup sequencer
  always @(posedge clk) begin
    if (!nrst) begin
      state_reg              <= ST_IDLE;
      mbr_reg                <= 5'h00;
      lk_group_valid_reg     <= 1'b0;
      lk_filter_group_id_reg <= 4'h0;
      fwd_valid_reg          <= 1'b0;
      fwd_ports_reg          <= 5'h00;
      fwd_drop_reg           <= 1'b0;
      fwd_learn_reg          <= 1'b0;
      fwd_refresh_reg        <= 1'b0;
      busy_reg               <= 1'b0;
    end else begin
      lk_group_valid_reg <= 1'b0;
      fwd_valid_reg      <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (lk_req && drop) begin
            fwd_valid_reg   <= 1'b1;
            fwd_ports_reg   <= 5'h00;
            fwd_drop_reg    <= 1'b1;
            fwd_learn_reg   <= 1'b0;
            fwd_refresh_reg <= 1'b0;
          end else if (lk_req) begin
            lk_group_valid_reg     <= 1'b1;
            lk_filter_group_id_reg <= vfid;
            mbr_reg                <= vmbr;
            busy_reg               <= 1'b1;
            state_reg              <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (res_valid) begin
            fwd_valid_reg   <= 1'b1;
            fwd_ports_reg   <= ports;
            fwd_drop_reg    <= 1'b0;
            fwd_learn_reg   <= !res_sa_hit;
            fwd_refresh_reg <= res_sa_hit;
            busy_reg        <= 1'b0;
            state_reg       <= ST_IDLE;
          end
        end
        default: begin
          busy_reg  <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  genvar p;
  generate
    for (p = 0; p < NP; p = p + 1) begin : g_port
      vlrl_rate_dir #(
        .LIM_W (LIM_W),
        .CNT_W (CNT_W)
      ) u_rx (
        .clk      (clk),
        .nrst     (nrst),
        .tick     (tick_reg),
        .prio_en  (pc_mem[p][`VLRL_PC_PRIO_BIT]),
        .fc_en    (pc_mem[p][`VLRL_PC_FC_BIT]),
        .lim_lo   (rxl_mem[p][`VLRL_LIM_LO_LSB +: LIM_W]),
        .lim_hi   (rxl_mem[p][`VLRL_LIM_HI_LSB +: LIM_W]),
        .sof      (rx_sof[p]),
        .byte_stb (rx_byte[p]),
        .eof      (rx_eof[p]),
        .prio_in  (rx_prio[p]),
        .stop_reg (rx_stop[2*p +: 2]),
        .fc_reg   (rx_fc[p])
      );
      vlrl_rate_dir #(
        .LIM_W (LIM_W),
        .CNT_W (CNT_W)
      ) u_tx (
        .clk      (clk),
        .nrst     (nrst),
        .tick     (tick_reg),
        .prio_en  (pc_mem[p][`VLRL_PC_PRIO_BIT]),
        .fc_en    (1'b0),
        .lim_lo   (txl_mem[p][`VLRL_LIM_LO_LSB +: LIM_W]),
        .lim_hi   (txl_mem[p][`VLRL_LIM_HI_LSB +: LIM_W]),
        .sof      (tx_sof[p]),
        .byte_stb (tx_byte[p]),
        .eof      (tx_eof[p]),
        .prio_in  (tx_prio[p]),
        .stop_reg (tx_stop[2*p +: 2]),
        .fc_reg   ()
      );
    end
  endgenerate

endmodule

// file: vlrl_map.vh
// Address map, field positions, reset values and timing for the VLAN
// lookup and rate limit block. Included by both design files.
`ifndef VLRL_MAP_VH
`define VLRL_MAP_VH

// Byte addresses on the APB register bus
`define VLRL_ADDR_CTRL       12'h000
`define VLRL_ADDR_STATUS     12'h004
`define VLRL_ADDR_VLAN_BASE  12'h040
`define VLRL_ADDR_PORT_BASE  12'h080
`define VLRL_ADDR_RXLIM_BASE 12'h0a0
`define VLRL_ADDR_TXLIM_BASE 12'h0c0
`define VLRL_MASK_VLAN       12'hfc0
`define VLRL_MASK_GROUP      12'hfe0

// Global control
`define VLRL_CTRL_VLAN_BIT   0

// VLAN table entry
`define VLRL_VE_VID_LSB      0
`define VLRL_VE_FID_LSB      12
`define VLRL_VE_MBR_LSB      16
`define VLRL_VE_VALID_BIT    21

// Port control
`define VLRL_PC_FC_BIT       0
`define VLRL_PC_PRIO_BIT     1
`define VLRL_PC_NONPVID_BIT  5
`define VLRL_PC_FILTER_BIT   6
`define VLRL_PC_PORT_DEFAULT_VLAN_LSB     16

// Limit registers, counts of 32 kbit/s steps
`define VLRL_LIM_LO_LSB      0
`define VLRL_LIM_HI_LSB      16

// Reset values
`define VLRL_CTRL_RST        32'h0000_0000
`define VLRL_PC_RST          32'h0001_0000
`define VLRL_LIM_RST         32'h0000_0000
`define VLRL_VE_RST          32'h0000_0000

// Timing
`define VLRL_INTERVAL_MS     1000
`define VLRL_CLK_KHZ         50000
`define VLRL_STEP_BPS        32000
`define VLRL_BYTES_PER_STEP  (`VLRL_STEP_BPS / 8)
`define VLRL_FC_RATE_STEPS   4
`define VLRL_FC_MARGIN_HI    8192
`define VLRL_FC_MARGIN_LO    2048

`endif

// file: vlrl_rate_dir.v
// One direction of one port's byte rate limiter, two traffic classes.
// Assumes byte, start and end strobes from a MAC on the same clock.
`include "vlrl_map.vh"

module vlrl_rate_dir #(
  parameter LIM_W = 12,
  parameter CNT_W = 24
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             tick,
  input  wire             prio_en,
  input  wire             fc_en,
  input  wire [LIM_W-1:0] lim_lo,
  input  wire [LIM_W-1:0] lim_hi,
  input  wire             sof,
  input  wire             byte_stb,
  input  wire             eof,
  input  wire             prio_in,
  output reg  [1:0]       stop_reg,
  output reg              fc_reg
);

  reg  [CNT_W-1:0] cnt_lo_reg;
  reg  [CNT_W-1:0] cnt_hi_reg;
  reg              in_frame_reg;
  reg              cls_hi_reg;
  wire             cls_hi;
  wire             over_lo;
  wire             over_hi;
  wire             near_lo;
  wire             near_hi;

  // Limit in bytes per interval
  function [CNT_W-1:0] lim_bytes;
    input [LIM_W-1:0] u;
    reg   [31:0]      t;
    begin
      t = u * `VLRL_BYTES_PER_STEP;
      lim_bytes = t[CNT_W-1:0];
    end
  endfunction

  function over;
    input [CNT_W-1:0] c;
    input [LIM_W-1:0] u;
    begin
      over = (u != {LIM_W{1'b0}}) && (c > lim_bytes(u));
    end
  endfunction

  function near;
    input [CNT_W-1:0] c;
    input [LIM_W-1:0] u;
    reg   [31:0]      w;
    reg   [CNT_W:0]   m;
    begin
      w = (u >= `VLRL_FC_RATE_STEPS) ? `VLRL_FC_MARGIN_HI : `VLRL_FC_MARGIN_LO;
      m = w[CNT_W:0];
      near = (u != {LIM_W{1'b0}}) && (({1'b0, c} + m) >= {1'b0, lim_bytes(u)});
    end
  endfunction

  assign cls_hi  = sof ? (prio_en & prio_in) : cls_hi_reg;
  assign over_lo = over(cnt_lo_reg, lim_lo);
  assign over_hi = over(cnt_hi_reg, lim_hi);
  assign near_lo = near(cnt_lo_reg, lim_lo);
  assign near_hi = near(cnt_hi_reg, lim_hi);

  always @(posedge clk) begin
    if (!nrst) begin
      cnt_lo_reg   <= {CNT_W{1'b0}};
      cnt_hi_reg   <= {CNT_W{1'b0}};
      in_frame_reg <= 1'b0;
      cls_hi_reg   <= 1'b0;
      stop_reg     <= 2'b00;
      fc_reg       <= 1'b0;
    end else begin
      // Single byte frame opens and closes at once
      if (sof || eof) begin
        in_frame_reg <= sof & !eof;
      end
      if (sof) begin
        cls_hi_reg <= prio_en & prio_in;
      end
      if (tick) begin
        cnt_lo_reg <= {CNT_W{1'b0}};
        cnt_hi_reg <= {CNT_W{1'b0}};
        stop_reg   <= 2'b00;
      end else begin
        if (byte_stb && cls_hi && !(&cnt_hi_reg)) begin
          cnt_hi_reg <= cnt_hi_reg + 1'b1;
        end
        if (byte_stb && !cls_hi && !(&cnt_lo_reg)) begin
          cnt_lo_reg <= cnt_lo_reg + 1'b1;
        end
        if (!in_frame_reg && !sof) begin
          stop_reg <= {prio_en & over_hi, over_lo};
        end
      end
      fc_reg <= fc_en & !tick & (near_lo | (prio_en & near_hi));
    end
  end

endmodule

// file: vlrl_monitor.sv
// Port assertions for the VLAN lookup and rate limit block.
// Bound into vlrl_top; one clock, synchronous active low reset.
module vlrl_monitor (
  input wire       clk,
  input wire       nrst,
  input wire       psel,
  input wire       penable,
  input wire       pready,
  input wire       lk_req,
  input wire       busy_reg,
  input wire       lk_group_valid_reg,
  input wire       fwd_valid_reg,
  input wire [4:0] fwd_ports_reg,
  input wire       fwd_drop_reg,
  input wire       fwd_learn_reg,
  input wire       fwd_refresh_reg,
  input wire       res_valid,
  input wire       res_static_hit,
  input wire       res_use_group_match_flag,
  input wire [4:0] res_static_ports,
  input wire       res_dyn_hit,
  input wire [2:0] res_dyn_port,
  input wire       res_sa_hit,
  input wire [4:0] rx_sof,
  input wire [4:0] rx_eof,
  input wire [9:0] rx_stop,
  input wire [9:0] tx_stop,
  input wire [4:0] rx_fc
);
  timeunit 1ns;
  timeprecision 1ns;
  reg rx_open_reg;
  wire ans = busy_reg && res_valid;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Port 0 receive frame in progress
  always @(posedge clk) begin
    if (!nrst)
      rx_open_reg <= 1'b0;
    else
      rx_open_reg <= (rx_open_reg | rx_sof[0]) & ~rx_eof[0];
  end
  apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  lk_answer_a: assert property (lk_req && !busy_reg |=> lk_group_valid_reg ^ fwd_valid_reg)
    else $error("lookup not answered");
  drop_clean_a: assert property (fwd_valid_reg && fwd_drop_reg |->
    fwd_ports_reg == 5'h00 && !fwd_learn_reg && !fwd_refresh_reg)
    else $error("dropped frame forwarded or learned");
  sa_learn_a: assert property (ans && !res_sa_hit |=> fwd_learn_reg && !fwd_refresh_reg)
    else $error("unknown source not learned");
  sa_refresh_a: assert property (ans && res_sa_hit |=> fwd_refresh_reg && !fwd_learn_reg)
    else $error("known source not refreshed");
  dyn_port_a: assert property (ans && !res_static_hit && res_dyn_hit |=>
    fwd_ports_reg == (5'h01 << $past(res_dyn_port)))
    else $error("dynamic port wrong");
  static_port_a: assert property (ans && res_static_hit && !res_use_group_match_flag |=>
    fwd_ports_reg == $past(res_static_ports))
    else $error("static ports wrong");
  stop_gap_a: assert property ($rose(rx_stop[0]) |-> !rx_open_reg)
    else $error("stop inside frame");
  stop_hold_a: assert property ($rose(rx_stop[0]) |=> rx_stop[0] [*8])
    else $error("stop released early");
  tick_all_a: assert property ($fell(rx_stop[0]) |-> !tx_stop[0] && !rx_fc[0])
    else $error("counters not cleared together");
endmodule

bind vlrl_top vlrl_monitor u_mon (.*);

// file: vlrl_fabric_model.sv
// Fabric table model: answers each group ready pulse with results.
// Assumes vlrl_top on the same clock; results from cfg dly+2 cycles after the group ready pulse.
module vlrl_fabric_model (
  input  wire        clk,
  input  wire        nrst,
  input  wire        lk_group_valid_reg,
  input  wire [15:0] cfg,
  input  wire [3:0]  dly,
  output wire        res_valid,
  output wire        res_static_hit,
  output wire        res_use_group_match_flag,
  output wire [3:0]  res_static_group,
  output wire [4:0]  res_static_ports,
  output wire        res_dyn_hit,
  output wire [2:0]  res_dyn_port,
  output wire        res_sa_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0] cnt_reg;
  reg       act_reg;
  reg       val_reg;
  // Inverted results outside the valid cycle
  assign {res_sa_hit, res_dyn_hit, res_dyn_port, res_static_ports, res_static_group,
          res_use_group_match_flag, res_static_hit} = val_reg ? cfg : ~cfg;
  assign res_valid = val_reg;
  always @(posedge clk) begin
    val_reg <= 1'b0;
    cnt_reg <= cnt_reg - 4'h1;
    if (!nrst) begin
      act_reg <= 1'b0;
    end else if (lk_group_valid_reg) begin
      act_reg <= 1'b1;
      cnt_reg <= dly;
    end else if (act_reg && cnt_reg == 4'h0) begin
      act_reg <= 1'b0;
      val_reg <= 1'b1;
    end
  end
endmodule

// file: test_vlan_lookup_rate_limit.sv
// Self-checking bench for the VLAN lookup and rate limit block.
// Drives APB, lookups and MAC strobes; the fabric is a model.
module test_vlan_lookup_rate_limit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IV = 20000;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, lk_vid = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        lk_req = 1'b0, lk_tagged = 1'b0, dir_tx = 1'b0;
  logic [2:0]  lk_port = 3'h0, res_dyn_port;
  logic [15:0] cfg = 16'h0000;
  logic [3:0]  dly = 4'h0, lk_filter_group_id_reg, res_static_group;
  logic [4:0]  sof_v = 5'h00, byt_v = 5'h00, eof_v = 5'h00, pri_v = 5'h00;
  logic        pready, pslverr, lk_group_valid_reg, fwd_valid_reg, busy_reg;
  logic        fwd_drop_reg, fwd_learn_reg, fwd_refresh_reg, res_valid, res_static_hit;
  logic        res_use_group_match_flag, res_dyn_hit, res_sa_hit;
  logic [4:0]  fwd_ports_reg, res_static_ports, rx_fc;
  logic [9:0]  rx_stop, tx_stop;
  wire  [4:0]  rx_sof = dir_tx ? 5'h00 : sof_v, tx_sof = dir_tx ? sof_v : 5'h00;
  wire  [4:0]  rx_byte = dir_tx ? 5'h00 : byt_v, tx_byte = dir_tx ? byt_v : 5'h00;
  wire  [4:0]  rx_eof = dir_tx ? 5'h00 : eof_v, tx_eof = dir_tx ? eof_v : 5'h00;
  wire  [4:0]  rx_prio = dir_tx ? 5'h00 : pri_v, tx_prio = dir_tx ? pri_v : 5'h00;
  int          fails = 0, checked = 0, cyc = 0;

  vlrl_top #(.INTERVAL_CYCLES(IV)) u_dut (.*);
  vlrl_fabric_model u_fab (.*);

  always #10 clk = ~clk;
  always @(posedge clk) if (nrst) cyc <= cyc + 1;

  task automatic end_sim;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo;
    fails++;
    $display("timeout at %0t", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      if (++n > 20) tmo();
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, xe);
  endtask
  task automatic look(input logic [2:0] p, input logic t, input logic [11:0] v,
                      input logic [15:0] c, input logic [3:0] g, input logic [7:0] e);
    int n = 0;
    logic sg = 1'b0;
    logic [3:0] gg = 4'h0;
    @(posedge clk);
    cfg <= c;
    lk_req <= 1'b1;
    lk_port <= p;
    lk_tagged <= t;
    lk_vid <= v;
    @(posedge clk);
    lk_req <= 1'b0;
    do begin
      @(posedge clk);
      if (lk_group_valid_reg === 1'b1) gg = lk_filter_group_id_reg;
      if (lk_group_valid_reg === 1'b1) sg = 1'b1;
      if (lk_group_valid_reg === 1'b1) chk(busy_reg, 1'b1);
      if (++n > 40) tmo();
    end while (fwd_valid_reg !== 1'b1);
    chk(sg, !e[7]);
    if (!e[7]) chk(gg, g);
    chk({fwd_drop_reg, fwd_learn_reg, fwd_refresh_reg, fwd_ports_reg}, e);
    chk(busy_reg, 1'b0);
  endtask
  task automatic frame(input int p, input logic pr, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sof_v <= (i == 0) ? 5'h01 << p : 5'h00;
      eof_v <= (i == n - 1) ? 5'h01 << p : 5'h00;
      byt_v <= 5'h01 << p;
      pri_v <= pr ? 5'h01 << p : 5'h00;
    end
    @(posedge clk);
    sof_v <= 5'h00;
    eof_v <= 5'h00;
    byt_v <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
  task automatic rate(input logic tx, input int p, input int h, input int st);
    int mg = (st >= 4) ? 8192 : 2048;
    logic [9:0] sv;
    wr((tx ? 12'h0c0 : 12'h0a0) + 12'(4 * p), 32'(st) << (16 * h));
    wr(12'h080 + 12'(4 * p), 32'h0001_0001 | 32'(2 * h));
    dir_tx <= tx;
    frame(p, h[0], st * 4000 - mg - 1);
    if (!tx && h == 0) chk(rx_fc[p], 1'b0);
    frame(p, h[0], 1);
    if (!tx && h == 0) chk(rx_fc[p], 1'b1);
    if (st < 4) begin
      frame(p, h[0], mg);
      sv = tx ? tx_stop : rx_stop;
      chk(sv[2 * p + h], 1'b0);
      frame(p, h[0], 1);
      sv = tx ? tx_stop : rx_stop;
      chk(sv[2 * p + h], 1'b1);
      chk(sv[2 * p + 1 - h], 1'b0);
    end
  endtask
  task automatic sync;
    int n = 0;
    while (cyc % IV != 50) begin
      @(posedge clk);
      if (++n > IV + 100) tmo();
    end
  endtask

  task automatic t_regs;
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h080, 32'h0001_0000, 1'b0);
    rd(12'h0c0, 32'h0, 1'b0);
    rd(12'hffc, 32'h0, 1'b1);
    wr(12'h090, 32'hffff_ffff);
    rd(12'h090, 32'h0fff_0063, 1'b0);
    wr(12'h090, 32'h0001_0000);
    $display("regs done");
  endtask
  task automatic t_vlan;
    look(3'd1, 1'b1, 12'h123, 16'h0000, 4'h0, 8'h5f);
    wr(12'h000, 32'h0000_0001);
    wr(12'h040, 32'h002a_5123);
    wr(12'h07c, 32'h0030_f7ff);
    look(3'd1, 1'b1, 12'h123, 16'h8000, 4'h5, 8'h2a);
    look(3'd1, 1'b1, 12'h123, 16'h0441, 4'h5, 8'h51);
    look(3'd1, 1'b1, 12'h123, 16'h5c53, 4'h5, 8'h48);
    look(3'd1, 1'b1, 12'h123, 16'h5000, 4'h5, 8'h44);
    dly <= 4'h5;
    look(3'd1, 1'b1, 12'h123, 16'h5997, 4'h5, 8'h46);
    look(3'd1, 1'b1, 12'h123, 16'h0453, 4'h5, 8'h4a);
    dly <= 4'h0;
    look(3'd4, 1'b1, 12'h7ff, 16'h8000, 4'hf, 8'h30);
    look(3'd1, 1'b1, 12'h555, 16'h8000, 4'h0, 8'h80);
    $display("vlan done");
  endtask
  task automatic t_filter;
    wr(12'h088, 32'h0123_0000);
    look(3'd2, 1'b0, 12'h7ff, 16'h8000, 4'h5, 8'h2a);
    look(3'd2, 1'b1, 12'h000, 16'h8000, 4'h5, 8'h2a);
    wr(12'h080, 32'h0001_0040);
    look(3'd0, 1'b1, 12'h123, 16'h8000, 4'h5, 8'h80);
    wr(12'h08c, 32'h0001_0020);
    look(3'd3, 1'b1, 12'h123, 16'h8000, 4'h5, 8'h80);
    wr(12'h08c, 32'h0123_0020);
    look(3'd3, 1'b1, 12'h123, 16'h8000, 4'h5, 8'h2a);
    $display("filter done");
  endtask
  task automatic t_rate;
    int n = 0;
    sync();
    rate(1'b0, 0, 0, 1);
    rate(1'b1, 0, 0, 1);
    rd(12'h004, 32'h0010_0401, 1'b0);
    while (rx_stop[0] !== 1'b0) begin
      @(posedge clk);
      if (++n > IV) tmo();
    end
    chk(tx_stop[0], 1'b0);
    chk(rx_fc[0], 1'b0);
    chk(cyc % IV < 8, 1'b1);
    rate(1'b0, 2, 1, 1);
    rate(1'b1, 4, 1, 1);
    sync();
    rate(1'b0, 1, 0, 4);
    $display("rate done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_vlan();
    t_filter();
    t_rate();
    end_sim();
  end
endmodule
